// File: rtl/trig_wait_pkg.sv
// Purpose: Shared constants and types of the trigger wait and sequencer block.
// Assumes: 100 MHz hclk; AHB-Lite register access with word transfers.
// Notes: Times are in microseconds; cycle counts derive from the clock rate.
//
// Overview of operation
// - Acquisition trigger outside acquisition wait is dropped and flagged as overtrigger.
// - Frame trigger outside frame wait is dropped and flagged as overtrigger.
// - Acquisition wait rises whenever sequencer enters acquisition wait state.
// - Acquisition wait falls when an accepted acquisition trigger leaves that state.
// - Frame wait rises whenever sequencer enters frame wait state.
// - Frame wait falls when an accepted frame trigger leaves that state.
// - Frame wait exists only while hardware frame triggering is enabled.
// - Acquisition wait can drive any output line 1 to 4 via select then source.
// - Frame wait can drive any output line 1 to 4 the same way.
// - Exposure starts a fixed variant delay of 37, 52, 60 or 71 us after trigger.
// - Debounce time, when enabled, is added to the exposure start delay.
// - After exposure ends, sensor readout into the frame buffer begins.
// - Transmission starts only after enough rows have accumulated in the buffer.
// - Transmission never finishes faster than readout; it trails the readout rows.
// - Readout time in microseconds for current settings is readable.
package trig_wait_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_FREQ_HZ = 100_000_000;
  localparam int US_CYC = CLK_FREQ_HZ / 1_000_000;
  localparam logic [7:0] DELAY_V0_US = 8'h25;
  localparam logic [7:0] DELAY_V1_US = 8'h34;
  localparam logic [7:0] DELAY_V2_US = 8'h3C;
  localparam logic [7:0] DELAY_V3_US = 8'h47;
  localparam logic [3:0] ROW_TIME_US = 4'h2;
  localparam logic [11:0] TX_START_ROWS = 12'h010;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] FRAMES_OFS = 8'h04;
  localparam logic [7:0] EXPOSURE_OFS = 8'h08;
  localparam logic [7:0] DEBOUNCE_OFS = 8'h0C;
  localparam logic [7:0] LINE_SEL_OFS = 8'h10;
  localparam logic [7:0] LINE_SRC_OFS = 8'h14;
  localparam logic [7:0] STATUS_OFS = 8'h18;
  localparam logic [7:0] READOUT_OFS = 8'h1C;
  localparam logic [7:0] HEIGHT_OFS = 8'h20;

  // ==========================================================================
  // Field positions and reset values
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_HWFRAME_BIT = 1;
  localparam int CTRL_DEBOUNCE_BIT = 2;
  localparam int CTRL_VARIANT_LSB = 4;
  localparam int ST_ACQ_OVR_BIT = 2;
  localparam int ST_FRM_OVR_BIT = 3;
  localparam logic [7:0] FRAMES_RST = 8'h01;
  localparam logic [15:0] EXPOSURE_RST = 16'h0064;
  localparam logic [11:0] HEIGHT_RST = 12'h0100;

  // Output line source codes.
  typedef enum logic [1:0] {
    SRC_LOW = 2'b00,
    SRC_ACQ_WAIT = 2'b01,
    SRC_FRAME_WAIT = 2'b10,
    SRC_EXPOSE = 2'b11
  } line_src_type;

  typedef struct packed {
    logic tx_active;
    logic readout_active;
    logic exposure_active;
    logic frame_ovr;
    logic acq_ovr;
    logic frame_wait;
    logic acq_wait;
  } seq_status_type;

endpackage

// File: rtl/trig_wait_seq.sv
// Purpose: Acquisition sequencer with trigger wait outputs and overtrigger flags.
// Assumes: Trigger pins are asynchronous; one AHB-Lite master, word transfers.
// Notes: Reads take one wait state; writes take none; response is always OKAY.
//
// Chosen here: register access over AHB-Lite and the address map.
`timescale 1ns/10ps
module trig_wait_seq (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Trigger pins
  input wire logic ext_acq_begin_trigger,
  input wire logic ext_frame_begin_trigger,
  // Status and output lines
  output logic acq_wait,
  output logic frame_wait,
  output logic acq_overtrigger,
  output logic frame_overtrigger,
  output logic exposure_active,
  output logic readout_active,
  output logic tx_active,
  output logic [3:0] line_out
);
  import trig_wait_pkg::*;

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_WAIT_ACQ = 5'b00010,
    S_WAIT_FRAME = 5'b00100,
    S_DELAY = 5'b01000,
    S_EXPOSE = 5'b10000
  } seq_state_type;

  seq_state_type state_r, state_nxt;
  logic [7:0] ctrl_r, frames_r, debounce_r, frames_left_r;
  logic [15:0] exposure_r, time_cnt_r, readout_us_r;
  logic [11:0] height_r, rd_rows_r, tx_rows_r;
  logic [1:0] line_sel_r;
  line_src_type line_src_r [4];
  logic acq_ovr_r, frame_ovr_r, rd_active_r, tx_active_r;
  logic [2:0] acq_sync_r, frm_sync_r;
  logic [6:0] us_cnt_r;
  logic us_tick_r;
  logic [3:0] row_us_r, tx_us_r;
  logic ap_valid_r, ap_write_r, rd_pend_r;
  logic [7:0] ap_addr_r;
  logic acq_edge, frm_edge, acq_take, frm_take, exp_done, wr_en, rd_go;
  logic [7:0] start_delay;
  seq_status_type status;

  // ==========================================================================
  // Bus slave
  assign rd_go = hsel && htrans[1] && hready && !hwrite;
  assign wr_en = ap_valid_r && ap_write_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid_r <= 1'b0;
      ap_write_r <= 1'b0;
      ap_addr_r <= 8'h00;
    end else if (hready) begin
      ap_valid_r <= hsel && htrans[1];
      ap_write_r <= hwrite;
      ap_addr_r <= haddr[7:0];
    end
  end

  // A read waits one cycle so a write in the data phase before it is seen.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_pend_r <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else begin
      rd_pend_r <= rd_go;
      hreadyout <= !rd_go;
      hresp <= 1'b0;
      if (rd_pend_r) begin
        unique case (ap_addr_r)
          CTRL_OFS: hrdata <= {24'h00_0000, ctrl_r};
          FRAMES_OFS: hrdata <= {24'h00_0000, frames_r};
          EXPOSURE_OFS: hrdata <= {16'h0000, exposure_r};
          DEBOUNCE_OFS: hrdata <= {24'h00_0000, debounce_r};
          LINE_SEL_OFS: hrdata <= {30'h0000_0000, line_sel_r};
          LINE_SRC_OFS: hrdata <= {30'h0000_0000, line_src_r[line_sel_r]};
          STATUS_OFS: hrdata <= {25'h000_0000, status};
          READOUT_OFS: hrdata <= {16'h0000, readout_us_r};
          HEIGHT_OFS: hrdata <= {20'h0_0000, height_r};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= 8'h00;
      frames_r <= FRAMES_RST;
      exposure_r <= EXPOSURE_RST;
      debounce_r <= 8'h00;
      height_r <= HEIGHT_RST;
      line_sel_r <= 2'b00;
    end else if (wr_en) begin
      unique case (ap_addr_r)
        CTRL_OFS: ctrl_r <= hwdata[7:0];
        FRAMES_OFS: frames_r <= hwdata[7:0];
        EXPOSURE_OFS: exposure_r <= hwdata[15:0];
        DEBOUNCE_OFS: debounce_r <= hwdata[7:0];
        LINE_SEL_OFS: line_sel_r <= hwdata[1:0];
        HEIGHT_OFS: height_r <= hwdata[11:0];
        default: ;
      endcase
    end
  end

  // Readout time follows the height setting.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      readout_us_r <= 16'h0000;
    end else begin
      readout_us_r <= 16'(height_r) * 16'(ROW_TIME_US);
    end
  end

  // ==========================================================================
  // Output line routing
  for (genvar i = 0; i < 4; i++) begin : g_line
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        line_src_r[i] <= SRC_LOW;
        line_out[i] <= 1'b0;
      end else begin
        if (wr_en && ap_addr_r == LINE_SRC_OFS && line_sel_r == 2'(i)) begin
          line_src_r[i] <= line_src_type'(hwdata[1:0]);
        end
        unique case (line_src_r[i])
          SRC_LOW: line_out[i] <= 1'b0;
          SRC_ACQ_WAIT: line_out[i] <= status.acq_wait;
          SRC_FRAME_WAIT: line_out[i] <= status.frame_wait;
          SRC_EXPOSE: line_out[i] <= status.exposure_active;
        endcase
      end
    end
  end

  // ==========================================================================
  // Trigger synchronisers and edge detection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acq_sync_r <= 3'b000;
      frm_sync_r <= 3'b000;
    end else begin
      acq_sync_r <= {acq_sync_r[1:0], ext_acq_begin_trigger};
      frm_sync_r <= {frm_sync_r[1:0], ext_frame_begin_trigger};
    end
  end

  assign acq_edge = acq_sync_r[1] && !acq_sync_r[2];
  assign frm_edge = frm_sync_r[1] && !frm_sync_r[2];
  assign acq_take = acq_edge && state_r == S_WAIT_ACQ;
  assign frm_take = frm_edge && state_r == S_WAIT_FRAME;

  // ==========================================================================
  // Microsecond tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      us_cnt_r <= 7'h00;
      us_tick_r <= 1'b0;
    end else begin
      us_tick_r <= us_cnt_r == 7'(US_CYC - 1);
      us_cnt_r <= (us_cnt_r == 7'(US_CYC - 1)) ? 7'h00 : us_cnt_r + 7'h01;
    end
  end

  // ==========================================================================
  // Sequencer
  always_comb begin
    unique case (ctrl_r[CTRL_VARIANT_LSB +: 2])
      2'b00: start_delay = DELAY_V0_US;
      2'b01: start_delay = DELAY_V1_US;
      2'b10: start_delay = DELAY_V2_US;
      2'b11: start_delay = DELAY_V3_US;
    endcase
  end

  // Exposure cannot end while the previous frame is still leaving the sensor.
  assign exp_done = state_r == S_EXPOSE && us_tick_r && time_cnt_r <= 16'h0001
                    && !rd_active_r && !tx_active_r;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      S_IDLE: if (ctrl_r[CTRL_RUN_BIT]) state_nxt = S_WAIT_ACQ;
      S_WAIT_ACQ: begin
        if (!ctrl_r[CTRL_RUN_BIT]) state_nxt = S_IDLE;
        else if (acq_take) state_nxt = ctrl_r[CTRL_HWFRAME_BIT] ? S_WAIT_FRAME : S_DELAY;
      end
      S_WAIT_FRAME: begin
        if (!ctrl_r[CTRL_RUN_BIT]) state_nxt = S_IDLE;
        else if (frm_take || !ctrl_r[CTRL_HWFRAME_BIT]) state_nxt = S_DELAY;
      end
      S_DELAY: if (us_tick_r && time_cnt_r <= 16'h0001) state_nxt = S_EXPOSE;
      S_EXPOSE: begin
        if (exp_done) begin
          if (frames_left_r > 8'h01) begin
            state_nxt = ctrl_r[CTRL_HWFRAME_BIT] ? S_WAIT_FRAME : S_DELAY;
          end else begin
            state_nxt = ctrl_r[CTRL_RUN_BIT] ? S_WAIT_ACQ : S_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= S_IDLE;
      time_cnt_r <= 16'h0000;
      frames_left_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      if (state_nxt == S_DELAY && state_r != S_DELAY) begin
        time_cnt_r <= {8'h00, start_delay}
                      + (ctrl_r[CTRL_DEBOUNCE_BIT] ? {8'h00, debounce_r} : 16'h0000);
      end else if (state_nxt == S_EXPOSE && state_r != S_EXPOSE) begin
        time_cnt_r <= (exposure_r == 16'h0000) ? 16'h0001 : exposure_r;
      end else if (us_tick_r && time_cnt_r > 16'h0001) begin
        time_cnt_r <= time_cnt_r - 16'h0001;
      end
      if (acq_take) begin
        frames_left_r <= (frames_r == 8'h00) ? 8'h01 : frames_r;
      end else if (exp_done) begin
        frames_left_r <= frames_left_r - 8'h01;
      end
    end
  end

  // Wait outputs line up with the registered state.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acq_wait <= 1'b0;
      frame_wait <= 1'b0;
      exposure_active <= 1'b0;
    end else begin
      acq_wait <= state_nxt == S_WAIT_ACQ;
      frame_wait <= state_nxt == S_WAIT_FRAME && ctrl_r[CTRL_HWFRAME_BIT];
      exposure_active <= state_nxt == S_EXPOSE;
    end
  end

  // ==========================================================================
  // Overtrigger pulses and sticky flags; a new event beats the clear.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acq_overtrigger <= 1'b0;
      frame_overtrigger <= 1'b0;
      acq_ovr_r <= 1'b0;
      frame_ovr_r <= 1'b0;
    end else begin
      acq_overtrigger <= acq_edge && !acq_take;
      frame_overtrigger <= frm_edge && !frm_take;
      if (acq_edge && !acq_take) acq_ovr_r <= 1'b1;
      else if (wr_en && ap_addr_r == STATUS_OFS && hwdata[ST_ACQ_OVR_BIT]) acq_ovr_r <= 1'b0;
      if (frm_edge && !frm_take) frame_ovr_r <= 1'b1;
      else if (wr_en && ap_addr_r == STATUS_OFS && hwdata[ST_FRM_OVR_BIT]) frame_ovr_r <= 1'b0;
    end
  end

  assign status = '{tx_active: tx_active_r, readout_active: rd_active_r,
                    exposure_active: exposure_active, frame_ovr: frame_ovr_r,
                    acq_ovr: acq_ovr_r, frame_wait: frame_wait, acq_wait: acq_wait};

  // ==========================================================================
  // Readout into the frame buffer and transmission out of it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_active_r <= 1'b0;
      rd_rows_r <= 12'h000;
      row_us_r <= 4'h0;
    end else if (exp_done) begin
      rd_active_r <= 1'b1;
      rd_rows_r <= 12'h000;
      row_us_r <= 4'h0;
    end else if (rd_active_r && us_tick_r) begin
      if (row_us_r == ROW_TIME_US - 4'h1) begin
        row_us_r <= 4'h0;
        rd_rows_r <= rd_rows_r + 12'h001;
        if (rd_rows_r + 12'h001 >= height_r) rd_active_r <= 1'b0;
      end else begin
        row_us_r <= row_us_r + 4'h1;
      end
    end
  end

  // The sender is paced at the readout row rate, so a frame never leaves faster than it is read.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_active_r <= 1'b0;
      tx_rows_r <= 12'h000;
      tx_us_r <= 4'h0;
    end else if (exp_done) begin
      tx_rows_r <= 12'h000;
      tx_us_r <= 4'h0;
    end else if (!tx_active_r) begin
      if (rd_rows_r != 12'h000 && tx_rows_r == 12'h000
          && (rd_rows_r >= TX_START_ROWS || !rd_active_r)) begin
        tx_active_r <= 1'b1;
      end
    end else if (us_tick_r && tx_rows_r < rd_rows_r) begin
      if (tx_us_r == ROW_TIME_US - 4'h1) begin
        tx_us_r <= 4'h0;
        tx_rows_r <= tx_rows_r + 12'h001;
        if (tx_rows_r + 12'h001 >= height_r) tx_active_r <= 1'b0;
      end else begin
        tx_us_r <= tx_us_r + 4'h1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      readout_active <= 1'b0;
      tx_active <= 1'b0;
    end else begin
      readout_active <= rd_active_r;
      tx_active <= tx_active_r;
    end
  end

  // ==========================================================================
  // Checks
  acq_drop_a: assert property (@(posedge hclk) disable iff (!hresetn)
    acq_edge && state_r != S_WAIT_ACQ
    |=> acq_overtrigger && (frames_left_r == $past(frames_left_r) || $past(exp_done)))
    else $error("acquisition overtrigger not flagged");
  frm_drop_a: assert property (@(posedge hclk) disable iff (!hresetn)
    frm_edge && state_r != S_WAIT_FRAME |=> frame_overtrigger)
    else $error("frame overtrigger not flagged");
  acq_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
    acq_wait == (state_r == S_WAIT_ACQ))
    else $error("acquisition wait mismatches state");
  acq_leave_a: assert property (@(posedge hclk) disable iff (!hresetn)
    acq_take && ctrl_r[CTRL_RUN_BIT] |=> !acq_wait)
    else $error("acquisition wait stayed high after trigger");
  frm_leave_a: assert property (@(posedge hclk) disable iff (!hresetn)
    frm_take && ctrl_r[CTRL_RUN_BIT] |=> !frame_wait ##1 state_r == S_DELAY)
    else $error("frame wait stayed high after trigger");
  frm_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    frame_wait |-> $past(ctrl_r[CTRL_HWFRAME_BIT]))
    else $error("frame wait without hardware frame triggering");
  line_route_a: assert property (@(posedge hclk) disable iff (!hresetn)
    line_src_r[0] == SRC_ACQ_WAIT && $stable(line_src_r[0]) |-> line_out[0] == $past(acq_wait))
    else $error("line 1 does not follow acquisition wait");
  delay_len_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == S_DELAY && $past(state_r) != S_DELAY && !ctrl_r[CTRL_DEBOUNCE_BIT]
    |-> time_cnt_r == {8'h00, start_delay})
    else $error("start delay loaded wrong");
  readout_go_a: assert property (@(posedge hclk) disable iff (!hresetn)
    exp_done |=> rd_active_r ##1 readout_active)
    else $error("readout did not start after exposure");
  tx_trail_a: assert property (@(posedge hclk) disable iff (!hresetn)
    tx_rows_r <= rd_rows_r || exp_done)
    else $error("transmission overtook readout");
  ovr_sticky_a: assert property (@(posedge hclk) disable iff (!hresetn)
    acq_overtrigger |-> acq_ovr_r)
    else $error("acquisition overtrigger not latched");

endmodule // trig_wait_seq

// File: tb/trig_source.sv
// Purpose: Behavioural external trigger source that watches the wait outputs.
// Assumes: Pins change by non-blocking assignment just after a rising edge.
// Notes: A pulse that is not told to obey fires at once, to provoke overtriggers.
`timescale 1ns/10ps
module trig_source (
  // Clock
  input wire logic hclk,
  // Wait outputs watched
  input wire logic acq_wait,
  input wire logic frame_wait,
  // Trigger pins
  output logic acq_pin,
  output logic frame_pin
);
  // ==========================================================================
  // Pulse generation
  initial begin
    acq_pin = 1'b0;
    frame_pin = 1'b0;
  end

  // The pin stays high three cycles and low three, so the block sees each edge once.
  task automatic pulse(input bit frame, input bit obey, output bit ok);
    int n;
    n = 0;
    ok = 1'b1;
    while (obey && (frame ? frame_wait : acq_wait) !== 1'b1 && n < 20000) begin
      @(posedge hclk);
      n++;
    end
    ok = (n < 20000);
    if (frame) frame_pin <= 1'b1;
    else acq_pin <= 1'b1;
    repeat (3) @(posedge hclk);
    frame_pin <= 1'b0;
    acq_pin <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask
endmodule // trig_source

// File: tb/tb_trig_wait_seq.sv
// Purpose: Self-checking bench for the trigger wait and sequencer block.
// Assumes: AHB-Lite master with single word transfers; 100 MHz hclk.
// Notes: HEIGHT and EXPOSURE are made small so that each frame stays short.
`timescale 1ns/10ps
module tb_trig_wait_seq;
  import trig_wait_pkg::*;
  localparam int W_ACQ = 0;
  localparam int W_FRM = 1;
  localparam int W_EXP = 2;
  localparam int W_RD = 3;
  localparam int W_TX = 4;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hreadyout, hresp, acq_pin, frame_pin, acq_wait, frame_wait;
  logic acq_overtrigger, frame_overtrigger, exposure_active, readout_active, tx_active;
  logic [3:0] line_out;
  logic [4:0] mon;
  logic [7:0] dly [4] = '{DELAY_V0_US, DELAY_V1_US, DELAY_V2_US, DELAY_V3_US};
  int err_total = 0;
  int total_checks = 0;
  int acq_ovr_cnt = 0;
  int frm_ovr_cnt = 0;

  assign mon = {tx_active, readout_active, exposure_active, frame_wait, acq_wait};

  trig_wait_seq trig_wait_seq_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ext_acq_begin_trigger(acq_pin), .ext_frame_begin_trigger(frame_pin),
    .acq_wait(acq_wait), .frame_wait(frame_wait), .acq_overtrigger(acq_overtrigger),
    .frame_overtrigger(frame_overtrigger), .exposure_active(exposure_active),
    .readout_active(readout_active), .tx_active(tx_active), .line_out(line_out));

  trig_source trig_source_inst (.hclk(hclk), .acq_wait(acq_wait), .frame_wait(frame_wait),
    .acq_pin(acq_pin), .frame_pin(frame_pin));

  // ==========================================================================
  // Clock, event counters and shared tasks
  always #5 hclk = ~hclk;

  always @(posedge hclk) begin
    if (acq_overtrigger === 1'b1) acq_ovr_cnt <= acq_ovr_cnt + 1;
    if (frame_overtrigger === 1'b1) frm_ovr_cnt <= frm_ovr_cnt + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // One transfer; the address phase is held until hready is seen high, then the data phase.
  task automatic bus(input bit wr, input logic [7:0] addr, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= {24'h00_0000, addr};
    htrans <= 2'b10;
    hwrite <= wr;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    rd = hrdata;
    chk(n < 100, 1'b1, "bus answer");
  endtask

  task automatic wait_sig(input int k, input logic lvl, output int n);
    n = 0;
    while (mon[k] !== lvl && n < 20000) begin
      @(posedge hclk);
      n++;
    end
  endtask

  task automatic conclude;
    if (err_total == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    logic [31:0] d;
    logic [7:0] ofs [5] = '{CTRL_OFS, FRAMES_OFS, EXPOSURE_OFS, HEIGHT_OFS, READOUT_OFS};
    logic [31:0] rv [5] = '{32'h0000_0000, 32'h0000_0001, 32'h0000_0064, 32'h0000_0100,
                            32'h0000_0200};
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, ofs[i], 32'h0000_0000, d);
      chk(d, rv[i], "reset value");
    end
    bus(1'b1, 8'h40, 32'hFFFF_FFFF, d);
    bus(1'b0, 8'h40, 32'h0000_0000, d);
    chk(d, 32'h0000_0000, "unmapped read");
    bus(1'b1, READOUT_OFS, 32'h1234_5678, d);
    bus(1'b1, HEIGHT_OFS, 32'h0000_0004, d);
    bus(1'b1, EXPOSURE_OFS, 32'h0000_0005, d);
    bus(1'b0, READOUT_OFS, 32'h0000_0000, d);
    chk(d, 32'h0000_0008, "readout time");
  endtask

  task automatic t_overtrig;
    logic [31:0] d;
    int n, c0;
    bit ok;
    bus(1'b1, CTRL_OFS, 32'h0000_0003, d);
    wait_sig(W_ACQ, 1'b1, n);
    chk(n < 2000, 1'b1, "acq wait after run");
    c0 = frm_ovr_cnt;
    trig_source_inst.pulse(1'b1, 1'b0, ok);
    chk(frm_ovr_cnt - c0, 1, "frame overtrigger pulses");
    bus(1'b0, STATUS_OFS, 32'h0000_0000, d);
    chk(d[ST_FRM_OVR_BIT], 1'b1, "sticky frame flag");
    bus(1'b1, STATUS_OFS, 32'h0000_0008, d);
    bus(1'b0, STATUS_OFS, 32'h0000_0000, d);
    chk(d[ST_FRM_OVR_BIT], 1'b0, "sticky flag cleared");
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, LINE_SEL_OFS, 32'(i), d);
      bus(1'b1, LINE_SRC_OFS, {30'h0, SRC_ACQ_WAIT}, d);
      repeat (2) @(posedge hclk);
      chk(line_out, (2 << i) - 1, "acq wait on line");
    end
    trig_source_inst.pulse(1'b0, 1'b1, ok);
    chk({acq_wait, frame_wait, line_out}, 6'b01_0000, "acq accepted");
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, LINE_SEL_OFS, 32'(i), d);
      bus(1'b1, LINE_SRC_OFS, {30'h0, SRC_FRAME_WAIT}, d);
      repeat (2) @(posedge hclk);
      chk(line_out, (2 << i) - 1, "frame wait on line");
    end
    c0 = acq_ovr_cnt;
    trig_source_inst.pulse(1'b0, 1'b0, ok);
    chk(acq_ovr_cnt - c0, 1, "acq overtrigger pulses");
    chk({acq_wait, frame_wait}, 2'b01, "state kept after drop");
  endtask

  task automatic t_frame(input logic [1:0] v, input logic [7:0] deb);
    logic [31:0] d;
    int n, el, expc;
    bit ok;
    time t0;
    bus(1'b1, DEBOUNCE_OFS, {24'h00_0000, deb}, d);
    bus(1'b1, CTRL_OFS, {26'h0, v, 1'b0, deb != 8'h00, 2'b11}, d);
    if (acq_wait === 1'b1) trig_source_inst.pulse(1'b0, 1'b1, ok);
    wait_sig(W_FRM, 1'b1, n);
    t0 = $time;
    trig_source_inst.pulse(1'b1, 1'b1, ok);
    chk(ok, 1'b1, "frame wait seen by source");
    chk(frame_wait, 1'b0, "frame wait falls");
    wait_sig(W_EXP, 1'b1, n);
    el = int'(($time - t0) / 10);
    expc = (int'(dly[v]) + int'(deb)) * US_CYC;
    chk(el > expc - 150 && el < expc + 150, 1'b1, "exposure start delay");
    wait_sig(W_EXP, 1'b0, n);
    wait_sig(W_RD, 1'b1, n);
    chk(n < 300 && tx_active === 1'b0, 1'b1, "readout follows exposure");
    t0 = $time;
    wait_sig(W_RD, 1'b0, n);
    el = int'(($time - t0) / 10);
    chk(el > 650 && el < 950, 1'b1, "readout length");
    wait_sig(W_TX, 1'b1, n);
    chk(n < 300, 1'b1, "transmission starts");
    t0 = $time;
    wait_sig(W_TX, 1'b0, n);
    el = int'(($time - t0) / 10);
    chk(n < 20000 && el > 650, 1'b1, "transmission trails readout");
    wait_sig(W_ACQ, 1'b1, n);
    chk(n < 20000, 1'b1, "acq wait again");
  endtask

  task automatic t_internal;
    logic [31:0] d;
    int hits, n;
    bit ok;
    hits = 0;
    bus(1'b1, CTRL_OFS, 32'h0000_0001, d);
    trig_source_inst.pulse(1'b0, 1'b1, ok);
    repeat (300) begin
      @(posedge hclk);
      if (frame_wait !== 1'b0) hits++;
    end
    chk(acq_wait === 1'b0 && hits == 0, 1'b1, "no frame wait when internal");
    bus(1'b1, LINE_SEL_OFS, 32'h0000_0000, d);
    bus(1'b1, LINE_SRC_OFS, {30'h0, SRC_EXPOSE}, d);
    wait_sig(W_EXP, 1'b1, n);
    repeat (2) @(posedge hclk);
    chk(n < 20000 && line_out[0] === 1'b1, 1'b1, "exposure on line");
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_overtrig();
    for (int v = 0; v < 4; v++) begin
      t_frame(2'(v), (v == 1) ? 8'h0F : 8'h00);
    end
    t_internal();
    conclude();
  end

  initial begin
    repeat (90000) @(posedge hclk);
    err_total++;
    conclude();
  end
endmodule // tb_trig_wait_seq
